/* rtl/lsc_top.sv */
// Light sensor conversion, threshold and interrupt logic with APB port
// Summary of operation
// - Two channels integrate simultaneously, 16-bit results
// - Finished cycle moves both results to data
// - Interrupt is a level at its own pin
// - Interrupt holds until firmware clears it
// - Out of range: above upper, below lower
// - Interrupt after programmed consecutive out-of-range count
// - Interrupt pin is open drain, active low
// - Host talks over fast serial bus, 400 kHz
// - Programmable wait 2.7 ms to over eight seconds
// - Optional sleep after interrupt is asserted
// - Host sets analog gain and integration time
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "lsc_defines.svh"
module lsc_top
    import lsc_pkg::*;
#(
    parameter int STEP_CYCLES = `LSC_STEP_US * `LSC_CLK_MHZ
) (
    input  wire logic        i_ref_clk,  // System clock, 125 MHz
    input  wire logic        i_rstn,     // Async reset, active low
    input  wire logic        i_conv_clk, // Conversion clock
    input  wire logic        i_vis_pkt,  // Visible plus IR charge packet
    input  wire logic        i_ir_pkt,   // IR only charge packet
    input  wire logic        i_psel,     // APB select
    input  wire logic        i_penable,  // APB enable
    input  wire logic        i_pwrite,   // APB direction
    input  wire logic [7:0]  i_paddr,    // APB byte address
    input  wire logic [31:0] i_pwdata,   // APB write data
    output logic      [31:0] o_prdata,   // APB read data
    output logic             o_pready,   // APB ready
    output logic             o_pslverr,  // APB error
    output logic      [1:0]  o_gain,     // Analog gain select
    output logic             o_int_o,    // Interrupt pin level
    output logic             o_int_oe    // Interrupt pin pull-down
);
    localparam logic [`LSC_CYC_W-1:0] STEP_LAST =
        `LSC_CYC_W'(STEP_CYCLES - 1);

    lsc_state_t           state_q;
    lsc_state_t           state_d;
    lsc_cfg_t             cfg_q;
    lsc_timing_t          tim_q;
    lsc_result_t          data_q;
    logic [15:0]          thr_lo_q;
    logic [15:0]          thr_hi_q;
    logic [3:0]           persist_q;
    logic [3:0]           run_q;
    logic [3:0]           run_inc;
    logic [3:0]           need;
    logic                 flag_q;
    logic                 valid_q;
    logic [`LSC_CYC_W-1:0] cyc_q;
    logic [11:0]          step_q;
    logic [11:0]          target;
    logic [11:0]          wait_base;
    logic                 tick;
    logic                 step_done;
    logic                 out_rng;
    logic                 trigger;
    logic                 gate_q;
    logic                 wr_en;
    logic                 int_clr;
    logic [31:0]          rdata_d;
    logic                 err_d;
    logic                 done_s;
    logic                 done_s_q;
    logic                 done_evt;
    logic                 crst_meta_q;
    logic                 crst_n_q;
    logic                 gate_s;
    logic                 gate_s_q;
    logic                 done_tgl_q;
    logic [15:0]          vis_hold;
    logic [15:0]          ir_hold;

    // Conversion clock domain
    always_ff @(posedge i_conv_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            crst_meta_q <= 1'b0;
            crst_n_q    <= 1'b0;
        end else begin
            crst_meta_q <= 1'b1;
            crst_n_q    <= crst_meta_q;
        end
    end

    lsc_sync #(.W(1)) u_gate_sync (
        .i_clk  (i_conv_clk),
        .i_rstn (crst_n_q),
        .i_d    (gate_q),
        .o_q    (gate_s)
    );

    // Both channels share one window so they convert together
    lsc_integrator u_vis (
        .i_clk   (i_conv_clk),
        .i_rstn  (crst_n_q),
        .i_gate  (gate_s),
        .i_pkt   (i_vis_pkt),
        .o_hold  (vis_hold)
    );

    lsc_integrator u_ir (
        .i_clk   (i_conv_clk),
        .i_rstn  (crst_n_q),
        .i_gate  (gate_s),
        .i_pkt   (i_ir_pkt),
        .o_hold  (ir_hold)
    );

    // Toggle tells the system side that the held words are stable
    always_ff @(posedge i_conv_clk or negedge crst_n_q) begin
        if (!crst_n_q) begin
            gate_s_q   <= 1'b0;
            done_tgl_q <= 1'b0;
        end else begin
            gate_s_q <= gate_s;
            if (gate_s_q && !gate_s) begin
                done_tgl_q <= ~done_tgl_q;
            end
        end
    end

    // System clock domain
    lsc_sync #(.W(1)) u_done_sync (
        .i_clk  (i_ref_clk),
        .i_rstn (i_rstn),
        .i_d    (done_tgl_q),
        .o_q    (done_s)
    );

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            done_s_q <= 1'b0;
        end else begin
            done_s_q <= done_s;
        end
    end

    assign done_evt = done_s ^ done_s_q;

    // Step timer shared by integration and wait
    assign wait_base = {4'h0, tim_q.wait_steps} + 12'h001;
    always_comb begin
        if (state_q == ST_INTEG) begin
            target = {4'h0, tim_q.integ_steps} + 12'h001;
        end else if (tim_q.long_wait) begin
            target = 12'(wait_base * `LSC_LONG_WAIT_MUL);
        end else begin
            target = wait_base;
        end
    end
    assign tick      = (cyc_q == STEP_LAST);
    assign step_done = tick && (step_q + 12'h001 == target);

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cyc_q  <= '0;
            step_q <= 12'h000;
        end else if (state_d != state_q) begin
            cyc_q  <= '0;
            step_q <= 12'h000;
        end else if (tick) begin
            cyc_q  <= '0;
            step_q <= step_q + 12'h001;
        end else begin
            cyc_q <= cyc_q + `LSC_CYC_W'(1);
        end
    end

    // Threshold check and persistence filter
    assign out_rng = (data_q.visible_ir_channel > thr_hi_q) ||
                     (data_q.visible_ir_channel < thr_lo_q);
    assign run_inc = (run_q == 4'hF) ? 4'hF : run_q + 4'h1;
    assign need    = (persist_q == 4'h0) ? 4'h1 : persist_q;
    assign trigger = (state_q == ST_EVAL) && out_rng &&
                     (run_inc >= need);

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            run_q <= 4'h0;
        end else if (!cfg_q.enable) begin
            run_q <= 4'h0;
        end else if (state_q == ST_EVAL) begin
            run_q <= out_rng ? run_inc : 4'h0;
        end
    end

    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (cfg_q.enable) begin
                    state_d = ST_INTEG;
                end
            end
            ST_INTEG: begin
                if (step_done) begin
                    state_d = ST_XFER;
                end
            end
            ST_XFER: begin
                if (done_evt) begin
                    state_d = ST_EVAL;
                end
            end
            ST_EVAL: begin
                if (cfg_q.sleep_after_int && cfg_q.int_en &&
                    (flag_q || trigger)) begin
                    state_d = ST_SLEEP;
                end else begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!cfg_q.enable) begin
                    state_d = ST_IDLE;
                end else if (step_done) begin
                    state_d = ST_INTEG;
                end
            end
            ST_SLEEP: begin
                if (!flag_q || !cfg_q.enable) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_IDLE;
            gate_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            gate_q  <= (state_d == ST_INTEG);
        end
    end

    // Result transfer
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            data_q  <= '0;
            valid_q <= 1'b0;
        end else if (state_q == ST_XFER && done_evt) begin
            data_q.visible_ir_channel <= vis_hold;
            data_q.ir_only_channel    <= ir_hold;
            valid_q                   <= 1'b1;
        end
    end

    // Host port; APB slave with the registers and the interrupt clear
    assign wr_en   = i_psel && i_penable && o_pready && i_pwrite;
    assign int_clr = wr_en && (i_paddr == `LSC_ADR_STATUS) &&
                     i_pwdata[`LSC_STAT_INT];

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= trigger || (flag_q && !int_clr);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_q     <= lsc_cfg_t'(`LSC_CTRL_RST);
            tim_q     <= lsc_timing_t'(`LSC_TIMING_RST);
            thr_lo_q  <= `LSC_THR_LO_RST;
            thr_hi_q  <= `LSC_THR_HI_RST;
            persist_q <= `LSC_PERSIST_RST;
        end else if (wr_en) begin
            if (i_paddr == `LSC_ADR_CTRL) begin
                cfg_q <= lsc_cfg_t'(i_pwdata[`LSC_CTRL_W-1:0]);
            end else if (i_paddr == `LSC_ADR_TIMING) begin
                tim_q <= lsc_timing_t'(i_pwdata[`LSC_TIM_W-1:0]);
            end else if (i_paddr == `LSC_ADR_THR_LO) begin
                thr_lo_q <= i_pwdata[15:0];
            end else if (i_paddr == `LSC_ADR_THR_HI) begin
                thr_hi_q <= i_pwdata[15:0];
            end else if (i_paddr == `LSC_ADR_PERSIST) begin
                persist_q <= i_pwdata[3:0];
            end
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d   = 1'b0;
        if (i_paddr == `LSC_ADR_CTRL) begin
            rdata_d[`LSC_CTRL_W-1:0] = cfg_q;
        end else if (i_paddr == `LSC_ADR_TIMING) begin
            rdata_d[`LSC_TIM_W-1:0] = tim_q;
        end else if (i_paddr == `LSC_ADR_THR_LO) begin
            rdata_d[15:0] = thr_lo_q;
        end else if (i_paddr == `LSC_ADR_THR_HI) begin
            rdata_d[15:0] = thr_hi_q;
        end else if (i_paddr == `LSC_ADR_PERSIST) begin
            rdata_d[3:0] = persist_q;
        end else if (i_paddr == `LSC_ADR_STATUS) begin
            rdata_d[`LSC_STAT_VALID]       = valid_q;
            rdata_d[`LSC_STAT_INT]         = flag_q;
            rdata_d[`LSC_STAT_STATE+2 -: 3] = state_q;
        end else if (i_paddr == `LSC_ADR_DATA_VIS) begin
            rdata_d[15:0] = data_q.visible_ir_channel;
        end else if (i_paddr == `LSC_ADR_DATA_IR) begin
            rdata_d[15:0] = data_q.ir_only_channel;
        end else begin
            err_d = 1'b1;
        end
    end

    // Answer is prepared in the setup cycle, so no wait states
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (i_psel && !i_penable) begin
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rdata_d;
            o_pready  <= 1'b1;
            o_pslverr <= err_d;
        end else begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    // Pin outputs
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_gain   <= 2'h0;
            o_int_o  <= 1'b0;
            o_int_oe <= 1'b0;
        end else begin
            o_gain   <= tim_q.gain;
            o_int_o  <= 1'b0;
            o_int_oe <= flag_q && cfg_q.int_en;
        end
    end
endmodule // lsc_top

/* rtl/lsc_defines.svh */
// Constants of the light sensor conversion block
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH
`define LSC_CLK_MHZ       125
`define LSC_STEP_US       2730
`define LSC_CYC_W         19
`define LSC_LONG_WAIT_MUL 4'hC
`define LSC_ADR_CTRL      8'h00
`define LSC_ADR_TIMING    8'h04
`define LSC_ADR_THR_LO    8'h08
`define LSC_ADR_THR_HI    8'h0C
`define LSC_ADR_PERSIST   8'h10
`define LSC_ADR_STATUS    8'h14
`define LSC_ADR_DATA_VIS  8'h18
`define LSC_ADR_DATA_IR   8'h1C
`define LSC_CTRL_W        3
`define LSC_TIM_W         19
`define LSC_STAT_VALID    0
`define LSC_STAT_INT      1
`define LSC_STAT_STATE    2
`define LSC_CTRL_RST      3'h0
`define LSC_TIMING_RST    19'h0_0000
`define LSC_THR_LO_RST    16'h0000
`define LSC_THR_HI_RST    16'hFFFF
`define LSC_PERSIST_RST   4'h0
`endif

/* rtl/lsc_pkg.sv */
// Types of the light sensor conversion block
package lsc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_INTEG = 3'b001,
        ST_XFER  = 3'b010,
        ST_EVAL  = 3'b011,
        ST_WAIT  = 3'b100,
        ST_SLEEP = 3'b101
    } lsc_state_t;

    typedef struct packed {
        logic sleep_after_int;
        logic int_en;
        logic enable;
    } lsc_cfg_t;

    typedef struct packed {
        logic       long_wait;
        logic [1:0] gain;
        logic [7:0] wait_steps;
        logic [7:0] integ_steps;
    } lsc_timing_t;

    typedef struct packed {
        logic [15:0] ir_only_channel;
        logic [15:0] visible_ir_channel;
    } lsc_result_t;
endpackage

/* rtl/lsc_sync.sv */
// Two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module lsc_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,  // Destination clock
    input  wire logic         i_rstn, // Async reset, active low
    input  wire logic [W-1:0] i_d,    // Foreign level
    output logic      [W-1:0] o_q     // Synchronised level
);
    logic [W-1:0] meta_q;

    for (genvar b = 0; b < W; b++) begin : g_bit
        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                meta_q[b] <= 1'b0;
                o_q[b]    <= 1'b0;
            end else begin
                meta_q[b] <= i_d[b];
                o_q[b]    <= meta_q[b];
            end
        end
    end
endmodule // lsc_sync

/* rtl/lsc_integrator.sv */
// Integrating counter of one light channel, in the conversion clock domain
`timescale 1ns/1ps
module lsc_integrator (
    input  wire logic        i_clk,   // Conversion clock
    input  wire logic        i_rstn,  // Reset, synchronous release
    input  wire logic        i_gate,  // Integration window, synced
    input  wire logic        i_pkt,   // Charge packet, raw
    output logic      [15:0] o_hold   // Result of the last window
);
    logic [2:0]  pls_q;
    logic        gate_q;
    logic [15:0] cnt_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pls_q  <= 3'h0;
            gate_q <= 1'b0;
            cnt_q  <= 16'h0000;
            o_hold <= 16'h0000;
        end else begin
            pls_q  <= {pls_q[1:0], i_pkt};
            gate_q <= i_gate;
            if (i_gate && !gate_q) begin
                cnt_q <= 16'h0000;
            end else if (i_gate && pls_q[1] && !pls_q[2] &&
                         cnt_q != 16'hFFFF) begin
                cnt_q <= cnt_q + 16'h0001;
            end
            if (!i_gate && gate_q) begin
                o_hold <= cnt_q;
            end
        end
    end
endmodule // lsc_integrator

/* verif/lsc_top_chk.sv */
// Port checker of the light sensor conversion block
`timescale 1ns/1ps
`include "lsc_defines.svh"
module lsc_top_chk (
    input wire logic        i_ref_clk, // Clock
    input wire logic        i_rstn,    // Reset
    input wire logic        i_psel,    // Select
    input wire logic        i_penable, // Enable
    input wire logic        i_pwrite,  // Direction
    input wire logic [7:0]  i_paddr,   // Address
    input wire logic [31:0] i_pwdata,  // Write data
    input wire logic [31:0] o_prdata,  // Read data
    input wire logic        o_pready,  // Ready
    input wire logic        o_pslverr, // Error
    input wire logic [1:0]  o_gain,    // Gain
    input wire logic        o_int_o,   // Pin level
    input wire logic        o_int_oe   // Pin pull-down
);
    logic acc;
    logic clr;
    logic wr_tim;
    logic rd_st;
    assign acc = i_psel && i_penable && o_pready;
    assign clr = acc && i_pwrite &&
                 ((i_paddr == `LSC_ADR_CTRL && !i_pwdata[1]) ||
                  (i_paddr == `LSC_ADR_STATUS && i_pwdata[1]));
    assign wr_tim = acc && i_pwrite && i_paddr == `LSC_ADR_TIMING;
    assign rd_st = acc && !i_pwrite && i_paddr == `LSC_ADR_STATUS;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);
    chk_ready_setup: assert property (
        i_psel && !i_penable |=> o_pready) else $error("no ready");
    chk_ready_single: assert property (
        o_pready |=> !o_pready) else $error("ready too long");
    chk_idle_zero: assert property (
        !o_pready |-> o_prdata == 32'h0000_0000) else $error("data idle");
    chk_err_map: assert property (
        o_pready |-> o_pslverr == (i_paddr > 8'h1F || i_paddr[1:0] != 2'h0))
        else $error("bad err");
    chk_pin_low: assert property (
        o_int_o == 1'h0) else $error("pin driven high");
    chk_int_hold: assert property (
        $fell(o_int_oe) |-> $past(clr, 2)) else $error("int dropped");
    chk_stat_int: assert property (
        rd_st && o_int_oe |-> o_prdata[1]) else $error("flag missing");
    chk_gain_copy: assert property (
        wr_tim |=> ##1 o_gain == $past(i_pwdata[17:16], 2))
        else $error("gain not copied");
    chk_data_width: assert property (
        acc && !i_pwrite && i_paddr[7:3] == 5'h03
        |-> o_prdata[31:16] == 16'h0000) else $error("data too wide");
    cov_unmapped: cover property (o_pslverr);
    cov_int_rise: cover property ($rose(o_int_oe));
    cov_int_clear: cover property ($fell(o_int_oe));
endmodule // lsc_top_chk

bind lsc_top lsc_top_chk u_lsc_top_chk (
    .i_ref_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_gain, .o_int_o,
    .o_int_oe
);

/* verif/lsc_light_src.sv */
// Light source model: counted charge packets for both channels
`timescale 1ns/1ps
module lsc_light_src (
    input  wire logic       i_clk,  // Conversion clock
    input  wire logic       i_rstn, // Reset, active low
    input  wire logic       i_go,   // Toggle starts a burst
    input  wire logic [7:0] i_nvis, // Visible plus IR packet count
    input  wire logic [7:0] i_nir,  // IR only packet count
    output logic            o_vis,  // Visible plus IR packets
    output logic            o_ir    // IR only packets
);
    logic [2:0] go_q;
    logic [1:0] ph_q;
    logic [7:0] rv_q;
    logic [7:0] ri_q;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            go_q <= 3'h0;
            ph_q <= 2'h0;
            rv_q <= 8'h00;
            ri_q <= 8'h00;
        end else begin
            go_q <= {go_q[1:0], i_go};
            ph_q <= ph_q + 2'h1;
            if (go_q[2] != go_q[1]) begin
                rv_q <= i_nvis;
                ri_q <= i_nir;
                ph_q <= 2'h0;
            end else if (ph_q == 2'h3) begin
                if (rv_q != 8'h00) rv_q <= rv_q - 8'h01;
                if (ri_q != 8'h00) ri_q <= ri_q - 8'h01;
            end
        end
    end
    // Same window for both channels, two clocks high and two low
    assign o_vis = ph_q[1] && rv_q != 8'h00;
    assign o_ir = ph_q[1] && ri_q != 8'h00;
endmodule // lsc_light_src

/* verif/lsc_top_bench.sv */
// Self-checking bench of the light sensor conversion block
`timescale 1ns/1ps
`include "lsc_defines.svh"
module lsc_top_bench;
    logic        i_ref_clk;
    logic        i_rstn;
    logic        i_conv_clk;
    logic        i_vis_pkt;
    logic        i_ir_pkt;
    logic        i_psel;
    logic        i_penable;
    logic        i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic [1:0]  o_gain;
    logic        o_int_o;
    logic        o_int_oe;
    logic        go;
    logic [7:0]  nvis;
    logic [7:0]  nir;
    int          mismatches;
    int          num_checks;
    int          cycles;

    lsc_top #(.STEP_CYCLES(64)) u_lsc_top (
        .i_ref_clk, .i_rstn, .i_conv_clk, .i_vis_pkt, .i_ir_pkt,
        .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .o_gain, .o_int_o, .o_int_oe
    );
    lsc_light_src u_lsc_light_src (
        .i_clk(i_conv_clk), .i_rstn(i_rstn), .i_go(go), .i_nvis(nvis),
        .i_nir(nir), .o_vis(i_vis_pkt), .o_ir(i_ir_pkt)
    );

    initial begin
        i_ref_clk = 1'h0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        i_conv_clk = 1'h0;
        #13;
        forever #40 i_conv_clk = ~i_conv_clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge i_ref_clk);
            cycles++;
            if (cycles == 80000) begin
                mismatches++;
                final_report();
            end
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    // One transfer; request held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        i_psel <= 1'h1;
        i_penable <= 1'h0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'h1;
        @(posedge i_ref_clk);
        while (o_pready !== 1'h1) begin
            @(posedge i_ref_clk);
        end
        q = o_prdata;
        e = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        @(posedge i_ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'h0, a, 32'h0000_0000, q, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'h1, a, d, q, e);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rd(a, q);
        chk(q, exp);
    endtask

    // Catches a fresh integration, fires a burst, returns at wait or sleep
    task automatic conv(input logic [7:0] nv, input logic [7:0] ni,
                        output logic [31:0] st);
        st = 32'h0000_0000;
        while (st[4:2] !== 3'h1) begin
            rd(`LSC_ADR_STATUS, st);
        end
        nvis <= nv;
        nir <= ni;
        go <= ~go;
        while (st[4:2] !== 3'h4 && st[4:2] !== 3'h5) begin
            rd(`LSC_ADR_STATUS, st);
        end
    endtask

    task automatic idle();
        logic [31:0] st;
        wr(`LSC_ADR_CTRL, 32'h0000_0000);
        st = 32'h0000_0004;
        for (int n = 0; n < 2000 && st[4:2] !== 3'h0; n++) begin
            rd(`LSC_ADR_STATUS, st);
        end
        chk(32'(st[4:2]), 32'h0000_0000);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic        e;
        for (int k = 0; k < 8; k++) begin
            rchk(8'(4 * k), k == 3 ? 32'h0000_FFFF : 32'h0000_0000);
        end
        apb(1'h0, 8'h40, 32'h0000_0000, q, e);
        chk(q, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [31:0] q;
        logic        e;
        for (int g = 0; g < 4; g++) begin
            wr(`LSC_ADR_TIMING, {14'h0000, g[1:0], 16'h001F});
            @(posedge i_ref_clk);
            chk(32'(o_gain), 32'(g));
        end
        rchk(`LSC_ADR_TIMING, 32'h0003_001F);
        wr(`LSC_ADR_DATA_VIS, 32'h0000_1234);
        rchk(`LSC_ADR_DATA_VIS, 32'h0000_0000);
        apb(1'h1, 8'h40, 32'h0000_0001, q, e);
        chk(32'(e), 32'h0000_0001);
        $display("test registers done");
    endtask

    task automatic t_conv();
        logic [31:0] st;
        int          n;
        wr(`LSC_ADR_CTRL, 32'h0000_0001);
        conv(8'h14, 8'h07, st);
        chk(32'(st[0]), 32'h0000_0001);
        rchk(`LSC_ADR_DATA_VIS, 32'h0000_0014);
        rchk(`LSC_ADR_DATA_IR, 32'h0000_0007);
        wr(`LSC_ADR_TIMING, 32'h0007_001F);
        conv(8'h00, 8'h0F, st);
        // Status polls every third cycle: 12 steps of 64 give 256
        n = 0;
        while (st[4:2] === 3'h4) begin
            rd(`LSC_ADR_STATUS, st);
            n++;
        end
        chk(32'(n), 32'h0000_0100);
        rchk(`LSC_ADR_DATA_VIS, 32'h0000_0000);
        rchk(`LSC_ADR_DATA_IR, 32'h0000_000F);
        $display("test conversion done");
    endtask

    task automatic t_persist();
        logic [31:0] st;
        logic [7:0]  seq [7];
        seq = '{8'h0B, 8'h04, 8'h0A, 8'h05, 8'h0B, 8'h04, 8'h14};
        idle();
        wr(`LSC_ADR_THR_LO, 32'h0000_0005);
        wr(`LSC_ADR_THR_HI, 32'hFFFF_000A);
        rchk(`LSC_ADR_THR_HI, 32'h0000_000A);
        wr(`LSC_ADR_PERSIST, 32'h0000_0003);
        wr(`LSC_ADR_CTRL, 32'h0000_0003);
        // Edge values are in range; in-range breaks the run
        foreach (seq[i]) begin
            conv(seq[i], 8'h00, st);
            chk(32'(st[1]), 32'(i == 6));
        end
        chk(32'(o_int_oe), 32'h0000_0001);
        chk(32'(o_int_o), 32'h0000_0000);
        conv(8'h08, 8'h00, st);
        wr(`LSC_ADR_STATUS, 32'h0000_0001);
        chk(32'(o_int_oe), 32'h0000_0001);
        wr(`LSC_ADR_STATUS, 32'h0000_0002);
        @(posedge i_ref_clk);
        chk(32'(o_int_oe), 32'h0000_0000);
        $display("test persistence done");
    endtask

    task automatic t_sleep();
        logic [31:0] st;
        idle();
        wr(`LSC_ADR_PERSIST, 32'h0000_0000);
        wr(`LSC_ADR_CTRL, 32'h0000_0007);
        conv(8'h14, 8'h00, st);
        repeat (200) @(posedge i_ref_clk);
        rd(`LSC_ADR_STATUS, st);
        chk(32'(st[4:2]), 32'h0000_0005);
        wr(`LSC_ADR_STATUS, 32'h0000_0002);
        idle();
        $display("test sleep done");
    endtask

    initial begin
        i_rstn = 1'h0;
        i_psel = 1'h0;
        i_penable = 1'h0;
        i_pwrite = 1'h0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0000_0000;
        go = 1'h0;
        nvis = 8'h00;
        nir = 8'h00;
        mismatches = 0;
        num_checks = 0;
        // Long enough for the slower clock to see the reset too
        repeat (6) @(posedge i_conv_clk);
        @(posedge i_ref_clk);
        i_rstn <= 1'h1;
        @(posedge i_ref_clk);
        t_reset();
        t_regs();
        t_conv();
        t_persist();
        t_sleep();
        final_report();
    end
endmodule // lsc_top_bench
